//--- rcf_regs.svh
// Offsets, field positions, codes and reset values of the request framer.
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH
`define RCF_START_DELIM     8'h7E
`define RCF_ESC_BYTE        8'h7D
`define RCF_ESC_XOR         8'h20
`define RCF_TYPE_REQ        8'h17
`define RCF_TYPE_RSP        8'h97
`define RCF_SUM_GOOD        8'hFF
`define RCF_CMD_APPLY       16'h4143
`define RCF_IDX_TYPE        16'h0000
`define RCF_IDX_ID          16'h0001
`define RCF_IDX_D64_FIRST   16'h0002
`define RCF_IDX_D64_LAST    16'h0009
`define RCF_IDX_D16_FIRST   16'h000A
`define RCF_IDX_D16_LAST    16'h000B
`define RCF_IDX_OPT         16'h000C
`define RCF_IDX_CMD_FIRST   16'h000D
`define RCF_IDX_CMD_LAST    16'h000E
`define RCF_MIN_LEN         16'h000F
`define RCF_PMAX            8
`define RCF_OPT_NOACK       0
`define RCF_OPT_APPLY       1
`define RCF_OPT_RSV2        2
`define RCF_OPT_RSV3        3
`define RCF_OPT_SECURE      4
`define RCF_REG_CTRL        4'h0
`define RCF_REG_STATUS      4'h4
`define RCF_REG_OKCNT       4'h8
`define RCF_REG_ERRCNT      4'hC
`define RCF_CTRL_ESC        0
`define RCF_CTRL_SESSION    1
`define RCF_STAT_PENDING    0
`define RCF_STAT_OUTVALID   1
`define RCF_CTRL_RESET      2'h0
`endif

//--- rcf_pkg.sv
// Types shared by the request framer.
`include "rcf_regs.svh"
package rcf_pkg;
    typedef enum logic [4:0] {
        RCF_IDLE   = 5'b00001,
        RCF_LEN_HI = 5'b00010,
        RCF_LEN_LO = 5'b00100,
        RCF_BODY   = 5'b01000,
        RCF_SUM    = 5'b10000
    } rcf_state_e;

    typedef struct packed {
        logic [7:0]                frame_id;
        logic                      resp_req;
        logic [7:0]                resp_type;
        logic [63:0]               dest64;
        logic [15:0]               dest16;
        logic                      disable_ack;
        logic                      apply_now;
        logic                      secure;
        logic                      is_query;
        logic [15:0]               command;
        logic [3:0]                param_len;
        logic [`RCF_PMAX*8-1:0]    param;
    } rcf_req_s;
endpackage : rcf_pkg

//--- rcf_framer.sv
// Parser of remote parameter request frames with a two-entry output buffer.
`timescale 1ns/1ps
module rcf_framer
    import rcf_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            rstn,
    input  wire logic [7:0]      in_byte,
    input  wire logic            in_valid,
    output logic                 in_ready,
    output rcf_req_s             out_req,
    output logic                 out_valid,
    input  wire logic            out_ready,
    output logic                 frame_ok,
    output logic                 frame_err,
    output logic                 changes_pending,
    input  wire logic [3:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata
);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [1:0]  ctrl_q;
    logic [31:0] ok_cnt_q;
    logic [31:0] err_cnt_q;
    logic [31:0] rdata_q;
    logic        head_v_q;
    logic        pend_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `RCF_CTRL_RESET;
        end else if (reg_wr && reg_addr == `RCF_REG_CTRL) begin
            ctrl_q <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0;
        end else if (reg_rd) begin
            if (reg_addr == `RCF_REG_CTRL) begin
                rdata_q <= {30'h0, ctrl_q};
            end else if (reg_addr == `RCF_REG_STATUS) begin
                rdata_q <= {30'h0, head_v_q, pend_q};
            end else if (reg_addr == `RCF_REG_OKCNT) begin
                rdata_q <= ok_cnt_q;
            end else if (reg_addr == `RCF_REG_ERRCNT) begin
                rdata_q <= err_cnt_q;
            end else begin
                rdata_q <= 32'h0;
            end
        end else begin
            rdata_q <= 32'h0;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Byte intake and unescaping
    // ------------------------------------------------------------
    logic       in_ready_q;
    logic       take;
    logic       esc_mode;
    logic       esc_q;
    logic       is_esc;
    logic       restart;
    logic       data_en;
    logic [7:0] b;

    assign esc_mode = ctrl_q[`RCF_CTRL_ESC];
    assign take     = in_valid & in_ready_q;
    assign is_esc   = esc_mode & (in_byte == `RCF_ESC_BYTE) & ~esc_q;
    assign b        = esc_q ? (in_byte ^ `RCF_ESC_XOR) : in_byte;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            esc_q <= 1'b0;
        end else if (take) begin
            esc_q <= is_esc;
        end
    end

    // ------------------------------------------------------------
    // Frame parser
    // ------------------------------------------------------------
    rcf_state_e  st_q;
    logic [15:0] len_q;
    logic [15:0] idx_q;
    logic [7:0]  sum_q;
    rcf_req_s    req_q;
    logic        bad_q;
    logic        push;
    logic        reject;
    logic        len_bad;
    logic [15:0] plen;

    assign plen    = len_q - `RCF_MIN_LEN;
    assign len_bad = (len_q < `RCF_MIN_LEN) || (plen > 16'(`RCF_PMAX));
    assign data_en = take & ~is_esc;
    // A start byte outside escaping is a frame boundary in escape mode, and otherwise only in RCF_IDLE.
    assign restart = data_en & ~esc_q & (in_byte == `RCF_START_DELIM) &
                     (esc_mode | st_q == RCF_IDLE);
    assign reject  = bad_q || len_bad ||
                     ((sum_q + b) != `RCF_SUM_GOOD) ||
                     (req_q.secure && !ctrl_q[`RCF_CTRL_SESSION]);
    assign push    = data_en & ~restart & (st_q == RCF_SUM) & ~reject;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= RCF_IDLE;
        end else if (restart) begin
            st_q <= RCF_LEN_HI;
        end else if (data_en) begin
            case (st_q)
                RCF_LEN_HI: st_q <= RCF_LEN_LO;
                RCF_LEN_LO: st_q <= ({len_q[15:8], b} == 16'h0) ?
                                    RCF_SUM : RCF_BODY;
                RCF_BODY:   st_q <= (idx_q == len_q - 16'h1) ?
                                    RCF_SUM : RCF_BODY;
                RCF_SUM:    st_q <= RCF_IDLE;
                default:    st_q <= RCF_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            len_q <= 16'h0;
            idx_q <= 16'h0;
            sum_q <= 8'h0;
        end else if (restart) begin
            idx_q <= 16'h0;
            sum_q <= 8'h0;
        end else if (data_en && st_q == RCF_LEN_HI) begin
            len_q <= {b, 8'h0};
        end else if (data_en && st_q == RCF_LEN_LO) begin
            len_q <= {len_q[15:8], b};
        end else if (data_en && st_q == RCF_BODY) begin
            idx_q <= idx_q + 16'h1;
            sum_q <= sum_q + b;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            req_q <= '0;
            bad_q <= 1'b0;
        end else if (restart) begin
            req_q <= '0;
            bad_q <= 1'b0;
        end else if (data_en && st_q == RCF_BODY) begin
            if (idx_q == `RCF_IDX_TYPE) begin
                bad_q           <= (b != `RCF_TYPE_REQ);
                req_q.resp_type <= `RCF_TYPE_RSP;
            end else if (idx_q == `RCF_IDX_ID) begin
                req_q.frame_id <= b;
                req_q.resp_req <= (b != 8'h0);
            end else if (idx_q <= `RCF_IDX_D64_LAST) begin
                req_q.dest64 <= {req_q.dest64[55:0], b};
            end else if (idx_q <= `RCF_IDX_D16_LAST) begin
                req_q.dest16 <= {req_q.dest16[7:0], b};
            end else if (idx_q == `RCF_IDX_OPT) begin
                req_q.disable_ack <= b[`RCF_OPT_NOACK];
                req_q.apply_now   <= b[`RCF_OPT_APPLY];
                req_q.secure      <= b[`RCF_OPT_SECURE];
            end else if (idx_q <= `RCF_IDX_CMD_LAST) begin
                req_q.command <= {req_q.command[7:0], b};
            end else begin
                req_q.param <= {req_q.param[`RCF_PMAX*8-9:0], b};
            end
        end else if (data_en && st_q == RCF_SUM) begin
            req_q.param_len <= plen[3:0];
            req_q.is_query  <= (plen == 16'h0);
        end
    end

    // ------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------
    rcf_req_s head_q;
    rcf_req_s spare_q;
    rcf_req_s push_req;
    logic     spare_v_q;
    logic     pop;
    logic     spare_v_d;

    always_comb begin
        push_req           = req_q;
        push_req.param_len = plen[3:0];
        push_req.is_query  = (plen == 16'h0);
    end

    assign pop = head_v_q & out_ready;

    always_comb begin
        spare_v_d = spare_v_q;
        if (pop || !head_v_q) begin
            spare_v_d = spare_v_q & push;
        end else if (push) begin
            spare_v_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            head_q    <= '0;
            spare_q   <= '0;
            head_v_q  <= 1'b0;
            spare_v_q <= 1'b0;
        end else begin
            spare_v_q <= spare_v_d;
            if (pop || !head_v_q) begin
                if (spare_v_q) begin
                    head_q   <= spare_q;
                    head_v_q <= 1'b1;
                    if (push) begin
                        spare_q <= push_req;
                    end
                end else begin
                    head_q   <= push_req;
                    head_v_q <= push;
                end
            end else if (push) begin
                spare_q <= push_req;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            in_ready_q <= 1'b0;
        end else begin
            in_ready_q <= ~spare_v_d;
        end
    end

    assign in_ready  = in_ready_q;
    assign out_req   = head_q;
    assign out_valid = head_v_q;

    // ------------------------------------------------------------
    // Status, counters and pending changes
    // ------------------------------------------------------------
    logic ok_q;
    logic err_q;
    logic fin;

    assign fin = data_en & ~restart & (st_q == RCF_SUM);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ok_q      <= 1'b0;
            err_q     <= 1'b0;
            ok_cnt_q  <= 32'h0;
            err_cnt_q <= 32'h0;
        end else begin
            ok_q  <= push;
            err_q <= fin & reject;
            if (push) begin
                ok_cnt_q <= ok_cnt_q + 32'h1;
            end
            if (fin && reject) begin
                err_cnt_q <= err_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
        end else if (push) begin
            if (req_q.apply_now || req_q.command == `RCF_CMD_APPLY) begin
                pend_q <= 1'b0;
            end else if (plen != 16'h0) begin
                pend_q <= 1'b1;
            end
        end
    end

    assign frame_ok        = ok_q;
    assign frame_err       = err_q;
    assign changes_pending = pend_q;

endmodule : rcf_framer

//--- rcf_framer_monitor.sv
// Checker of the request framer port behaviour.
`timescale 1ns/1ps
`include "rcf_regs.svh"
module rcf_framer_monitor
    import rcf_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire rcf_req_s    out_req,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic        frame_ok,
    input wire logic        frame_err,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata
);
    // ------------------------------------------------------------
    // Port assertions.
    // ------------------------------------------------------------
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence s_good;
        frame_ok;
    endsequence
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    property p_pulse;
        s_good |=> !frame_ok && !frame_err;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("frame_ok longer than one cycle");
    property p_excl;
        !(frame_ok && frame_err);
    endproperty
    a_excl: assert property (p_excl)
        else $error("frame_ok and frame_err together");
    property p_push;
        s_good |-> out_valid;
    endproperty
    a_push: assert property (p_push)
        else $error("good frame not presented");
    property p_rsp;
        out_valid |-> out_req.resp_type == `RCF_TYPE_RSP;
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("wrong response type");
    property p_id;
        out_valid |-> out_req.resp_req == (out_req.frame_id != 8'h00);
    endproperty
    a_id: assert property (p_id)
        else $error("response request does not follow id");
    property p_qry;
        out_valid |-> out_req.is_query == (out_req.param_len == 4'h0);
    endproperty
    a_qry: assert property (p_qry)
        else $error("query flag does not follow length");
    property p_plen;
        out_valid |-> out_req.param_len <= 4'h8;
    endproperty
    a_plen: assert property (p_plen)
        else $error("parameter length too large");
    property p_hold;
        s_stall |=> out_valid && $stable(out_req);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled request changed");
    property p_rd;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data outside read cycle");
endmodule : rcf_framer_monitor

bind rcf_framer rcf_framer_monitor u_rcf_framer_monitor (
    .mclk(mclk), .rstn(rstn), .out_req(out_req), .out_valid(out_valid),
    .out_ready(out_ready), .frame_ok(frame_ok), .frame_err(frame_err),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

//--- rcf_host.sv
// Host controller model that sends request frames byte by byte.
`timescale 1ns/1ps
`include "rcf_regs.svh"
module rcf_host (
    input  wire logic       mclk,
    input  wire logic       in_ready,
    output logic [7:0]      in_byte,
    output logic            in_valid,
    output logic            hung
);
    // ------------------------------------------------------------
    // Byte and frame senders.
    // ------------------------------------------------------------
    logic esc_on;
    initial begin
        in_byte = 8'h00;
        in_valid = 1'b0;
        hung = 1'b0;
        esc_on = 1'b0;
    end
    task automatic put(input logic [7:0] b);
        int n;
        n = 0;
        in_byte <= b;
        in_valid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (in_ready !== 1'b1 && n < 200);
        if (n >= 200) hung = 1'b1;
    endtask : put
    task automatic put_x(input logic [7:0] b);
        if (esc_on && (b == `RCF_START_DELIM || b == `RCF_ESC_BYTE)) begin
            put(`RCF_ESC_BYTE);
            put(b ^ `RCF_ESC_XOR);
        end else begin
            put(b);
        end
    endtask : put_x
    task automatic frame(input logic [7:0] body[$], input logic bad);
        logic [7:0] sum;
        sum = 8'h00;
        @(posedge mclk);
        put(`RCF_START_DELIM);
        put_x(8'(body.size() >> 8));
        put_x(8'(body.size()));
        foreach (body[i]) begin
            put_x(body[i]);
            sum = sum + body[i];
        end
        put_x((8'hFF - sum) ^ {7'h0, bad});
        in_valid <= 1'b0;
        in_byte <= ~in_byte;
    endtask : frame
endmodule : rcf_host

//--- remote_cmd_request_framer_test.sv
// Self-checking testbench of the remote parameter request framer.
`timescale 1ns/1ps
`include "rcf_regs.svh"
module remote_cmd_request_framer_test
    import rcf_pkg::*;
;
    // ------------------------------------------------------------
    // Bench, tasks and scenarios.
    // ------------------------------------------------------------
    // Arbitrary single-node destination, never a broadcast address.
    localparam logic [63:0] D64 = 64'h1122334455667788;
    logic        mclk, rstn, in_valid, in_ready, out_valid, out_ready;
    logic        frame_ok, frame_err, changes_pending, reg_wr, reg_rd, hung;
    logic [7:0]  in_byte;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    rcf_req_s    out_req;
    int          n_errors, samples_checked;
    logic [7:0]  body[$];
    rcf_framer u_rcf_framer (.mclk(mclk), .rstn(rstn), .in_byte(in_byte),
        .in_valid(in_valid), .in_ready(in_ready), .out_req(out_req),
        .out_valid(out_valid), .out_ready(out_ready), .frame_ok(frame_ok),
        .frame_err(frame_err), .changes_pending(changes_pending),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    rcf_host u_rcf_host (.mclk(mclk), .in_ready(in_ready),
        .in_byte(in_byte), .in_valid(in_valid), .hung(hung));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [63:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input string nm, input logic [3:0] a, logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask : rd
    task automatic mk(input logic [7:0] t, i, o, input logic [15:0] c,
                      input int np, input logic [63:0] p);
        body = {t, i};
        for (int k = 7; k >= 0; k--) body.push_back(D64[k*8 +: 8]);
        body.push_back(8'hFF);
        body.push_back(8'hFE);
        body.push_back(o);
        body.push_back(c[15:8]);
        body.push_back(c[7:0]);
        for (int k = np - 1; k >= 0; k--) body.push_back(p[k*8 +: 8]);
    endtask : mk
    task automatic send(input logic bad, input logic ok);
        int n;
        n = 0;
        u_rcf_host.frame(body, bad);
        #1;
        while (frame_ok !== 1'b1 && frame_err !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n >= 8 || hung) begin
            n_errors++;
            wrap_up();
        end
        chk("frame_ok", ok, frame_ok);
        chk("frame_err", !ok, frame_err);
    endtask : send
    task automatic chk_req(input logic [7:0] i, o, input logic [15:0] c,
                           input int np, input logic [63:0] p);
        chk("frame_id", i, out_req.frame_id);
        chk("resp_req", i != 8'h00, out_req.resp_req);
        chk("resp_type", `RCF_TYPE_RSP, out_req.resp_type);
        chk("dest64", D64, out_req.dest64);
        chk("dest16", 16'hFFFE, out_req.dest16);
        chk("disable_ack", o[0], out_req.disable_ack);
        chk("apply_now", o[1], out_req.apply_now);
        chk("command", c, out_req.command);
        chk("param_len", np, out_req.param_len);
        chk("param", p, out_req.param);
        chk("is_query", np == 0, out_req.is_query);
    endtask : chk_req
    task automatic t_set();
        mk(8'h17, 8'h27, 8'h02, 16'h4E49, 6, 64'h52656D6F7465);
        send(1'b0, 1'b1);
        chk_req(8'h27, 8'h02, 16'h4E49, 6, 64'h52656D6F7465);
    endtask : t_set
    task automatic t_queue();
        mk(8'h17, 8'h68, 8'h00, 16'h4944, 2, 64'h0451);
        send(1'b0, 1'b1);
        chk("pending_set", 1'b1, changes_pending);
        rd("status_pending", `RCF_REG_STATUS, 32'h1);
        mk(8'h17, 8'h05, 8'h00, `RCF_CMD_APPLY, 0, 64'h0);
        send(1'b0, 1'b1);
        chk("pending_clr", 1'b0, changes_pending);
        rd("status_applied", `RCF_REG_STATUS, 32'h0);
    endtask : t_queue
    task automatic t_query();
        mk(8'h17, 8'h00, 8'h01, 16'h5450, 0, 64'h0);
        send(1'b0, 1'b1);
        chk_req(8'h00, 8'h01, 16'h5450, 0, 64'h0);
    endtask : t_query
    task automatic t_bad();
        mk(8'h17, 8'h33, 8'h00, 16'h5450, 0, 64'h0);
        send(1'b1, 1'b0);
        mk(8'h10, 8'h34, 8'h00, 16'h5450, 0, 64'h0);
        send(1'b0, 1'b0);
    endtask : t_bad
    task automatic t_secure();
        mk(8'h17, 8'h31, 8'h12, 16'h4E49, 1, 64'h41);
        send(1'b0, 1'b0);
        wr(`RCF_REG_CTRL, 32'h2);
        send(1'b0, 1'b1);
        chk("secure", 1'b1, out_req.secure);
        wr(`RCF_REG_CTRL, 32'h0);
        rd("ctrl", `RCF_REG_CTRL, 32'h0);
    endtask : t_secure
    task automatic t_esc();
        wr(`RCF_REG_CTRL, 32'h1);
        u_rcf_host.esc_on = 1'b1;
        mk(8'h17, 8'h7D, 8'h02, 16'h4E49, 2, 64'h7E7D);
        send(1'b0, 1'b1);
        chk_req(8'h7D, 8'h02, 16'h4E49, 2, 64'h7E7D);
        u_rcf_host.esc_on = 1'b0;
        wr(`RCF_REG_CTRL, 32'h0);
    endtask : t_esc
    task automatic t_stall();
        @(posedge mclk);
        out_ready <= 1'b0;
        mk(8'h17, 8'h41, 8'h02, 16'h5450, 0, 64'h0);
        send(1'b0, 1'b1);
        mk(8'h17, 8'h42, 8'h02, 16'h5450, 0, 64'h0);
        send(1'b0, 1'b1);
        @(posedge mclk);
        #1 chk("in_ready_full", 1'b0, in_ready);
        chk("head_id", 8'h41, out_req.frame_id);
        rd("status_full", `RCF_REG_STATUS, 32'h2);
        @(posedge mclk);
        out_ready <= 1'b1;
        @(posedge mclk);
        #1 chk("next_id", 8'h42, out_req.frame_id);
        @(posedge mclk);
        #1 chk("drained", 1'b0, out_valid);
    endtask : t_stall
    initial begin
        rstn = 1'b0;
        out_ready = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rd("ctrl_reset", `RCF_REG_CTRL, 32'h0);
        t_set();
        t_queue();
        t_query();
        t_bad();
        t_secure();
        t_esc();
        t_stall();
        rd("ok_count", `RCF_REG_OKCNT, 32'h8);
        rd("err_count", `RCF_REG_ERRCNT, 32'h3);
        rd("unmapped", 4'h2, 32'h0);
        wrap_up();
    end
endmodule : remote_cmd_request_framer_test
